// File: verilog/reset_source_controller.sv
// Reset source controller: gathers reset requests, sequences the system
// reset, records the cause and holds the supply monitor control register.
// Assumes all inputs are synchronous to CLOCK_IN and that NRST_IN is the
// power-on reset from the analog supervisor.
//
// Overview of operation
// - Monitor enable bit seven switches monitor
// - Monitor resets only when selected as source
// - Bit six shows live supply status
// - Monitor bits five to zero read zero
// - External pin low puts device in reset
// - Pin reset sets pin flag on exit
// - Lost clock detector resets on stalled clock
// - Lost clock flag set only after its reset
// - Writing detector bit enables or disables it
// - Only power-on and monitor resets drive reset pin low
// - Writing bit five selects comparator source
// - Selected comparator low holds device in reset
// - Comparator flag set only after its reset
// - Watchdog enabled after reset, clocked by twelve
// - Watchdog expiry resets and sets its flag
// - Illegal flash access causes system reset
// - Flash error reset sets bit six
// - Writing bit four forces reset, flags it
// - Selected bus resets on signalling or supply edge
// - Bus reset flag set after bus reset
// - Power-on or monitor reset sets bit one
// - Monitor enabled at power-on, kept otherwise
// - Cause register at address ef on all pages
`timescale 1ns/100ps
`default_nettype none

module reset_source_controller
  import reset_cause_pkg::*;
#(
  parameter int MCD_COUNT  = reset_cause_pkg::MCD_CYCLES,  // Lost clock time-out in cycles
  parameter int WDT_TICKS  = reset_cause_pkg::WDT_LIMIT,   // Watchdog expiry in ticks
  parameter int HOLD_COUNT = reset_cause_pkg::HOLD_CYCLES  // Least hold in reset
) (
  // Clock and power-on reset
  input  wire logic                     CLOCK_IN,
  input  wire logic                     NRST_IN,
  // Special register bus
  input  wire reset_cause_pkg::sfr_req_t SFR_REQ_IN,
  output logic [7:0]                    SFR_RDATA_OUT,
  // Reset pin, open drain
  input  wire logic                     RST_PIN_IN,
  output logic                          RST_PIN_OUT,
  output logic                          RST_PIN_OE_OUT,
  // Analog and peripheral sources
  input  wire logic                     SUPPLY_OK_IN,
  input  wire logic                     SYSCLK_LEVEL_IN,
  input  wire logic                     CMP_OUT_IN,
  input  wire logic                     WDT_SERVICE_IN,
  input  wire logic                     WDT_DISABLE_IN,
  input  wire logic                     FLASH_ERR_IN,
  input  wire logic                     FLASH_WRITE_IN,
  input  wire logic                     USB_ENABLED_IN,
  input  wire logic                     USB_BUS_RESET_IN,
  input  wire logic                     VBUS_IN,
  // System reset and monitor control
  output logic                          SYS_RST_N_OUT,
  output logic                          MON_ENABLE_OUT
);

  import reset_cause_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  seq_state_t  state_q, state_d;       // Sequencer state
  logic [15:0] hold_q, hold_d;         // Cycles spent in reset
  cause_t      cause_q, cause_d;       // Cause latched at entry
  cause_t      flags_q, flags_d;       // Cause shown to software
  logic        mon_en_q, mon_en_d;     // Supply monitor on
  logic        mon_sel_q, mon_sel_d;   // Monitor selected as source
  logic        mcd_en_q, mcd_en_d;     // Lost clock detector on
  logic        cmp_en_q, cmp_en_d;     // Comparator selected
  logic        usb_en_q, usb_en_d;     // Bus reset selected
  logic        sw_req_q, sw_req_d;     // Software force pending
  logic [15:0] mcd_cnt_q, mcd_cnt_d;   // Time since last clock edge
  logic        clk_lvl_q, clk_lvl_d;   // Last seen system clock level
  logic [3:0]  div_q, div_d;           // Divide-by-twelve counter
  logic        wdt_en_q, wdt_en_d;     // Watchdog running
  logic [15:0] wdt_q, wdt_d;           // Watchdog ticks
  logic        vbus_q, vbus_d;         // Previous bus supply level
  logic [7:0]  rdata_q, rdata_d;       // Read data register
  cause_t      req;                    // Live reset requests
  logic        any_req;                // Any request present
  logic        level_req;              // Level requests still present
  logic        wdt_tick;               // One-cycle tick at clock / 12
  logic        running;                // Core out of reset

  // Narrowing helper for counters compared against integer parameters
  function automatic logic [15:0] to16(input int v);
    to16 = v[15:0];
  endfunction : to16

  // Picks a single cause, most fundamental first, so flags stay one-hot
  function automatic cause_t pick_one(input cause_t r);
    cause_t c;
    c = CAUSE_NONE;
    if (r.por)        c.por   = 1'b1;
    else if (r.pin)   c.pin   = 1'b1;
    else if (r.lost_clock_detector)   c.lost_clock_detector   = 1'b1;
    else if (r.cmp)   c.cmp   = 1'b1;
    else if (r.wdt)   c.wdt   = 1'b1;
    else if (r.flash) c.flash = 1'b1;
    else if (r.sw)    c.sw    = 1'b1;
    else if (r.usb)   c.usb   = 1'b1;
    pick_one = c;
  endfunction : pick_one

  assign running = state_q[0];

  // ****************************************
  // Request gathering
  // ****************************************
  // Combines each selectable source with its enable; inputs are synchronous so no filter
  always_comb begin
    req       = CAUSE_NONE;
    req.por   = mon_en_q && mon_sel_q && !SUPPLY_OK_IN;
    // Our own drive shows on the pin too, so it is ignored while driving
    req.pin   = !RST_PIN_IN && !RST_PIN_OE_OUT;
    req.lost_clock_detector   = mcd_en_q && (mcd_cnt_q >= to16(MCD_COUNT));
    req.cmp   = cmp_en_q && !CMP_OUT_IN;
    req.wdt   = wdt_en_q && (wdt_q >= to16(WDT_TICKS));
    req.flash = FLASH_ERR_IN || (FLASH_WRITE_IN && !mon_en_q);
    req.sw    = sw_req_q;
    req.usb   = usb_en_q && ((USB_BUS_RESET_IN && USB_ENABLED_IN) ||
                             (VBUS_IN != vbus_q));
    any_req   = |req;
    level_req = req.por || req.pin || req.cmp;
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Hold reset for a least time and while a level source persists
  always_comb begin
    state_d = state_q;
    hold_d  = hold_q;
    cause_d = cause_q;
    flags_d = flags_q;
    case (state_q)
      ST_RUN: begin
        hold_d = '0;
        if (any_req) begin
          state_d = ST_HOLD;
          cause_d = pick_one(req);
        end
      end
      ST_HOLD: begin
        // A level source restarts the hold so release follows its removal
        if (level_req) begin
          hold_d = '0;
        end else if (hold_q < to16(HOLD_COUNT)) begin
          hold_d = hold_q + 16'h0001;
        end else begin
          state_d = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        // Old flags are replaced whole, so only the latest cause shows
        flags_d = cause_q;
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
  end

  // Registers the sequencer; power-on reset records the power-on cause
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_q <= ST_HOLD;
      hold_q  <= '0;
      cause_q <= CAUSE_POR;
      flags_q <= CAUSE_NONE;
    end else begin
      state_q <= state_d;
      hold_q  <= hold_d;
      cause_q <= cause_d;
      flags_q <= flags_d;
    end
  end

  // ****************************************
  // Control bits and register writes
  // ****************************************
  // Writes take effect only while the core runs
  always_comb begin
    mon_en_d  = mon_en_q;
    mon_sel_d = mon_sel_q;
    mcd_en_d  = mcd_en_q;
    cmp_en_d  = cmp_en_q;
    usb_en_d  = usb_en_q;
    sw_req_d  = 1'b0;
    if (running && SFR_REQ_IN.wr) begin
      if (SFR_REQ_IN.addr == ADDR_MON_CTRL) begin
        mon_en_d = SFR_REQ_IN.wdata[MON_EN_BIT];
      end else if (SFR_REQ_IN.addr == ADDR_RST_CAUSE) begin
        mon_sel_d = SFR_REQ_IN.wdata[BIT_POR];
        mcd_en_d  = SFR_REQ_IN.wdata[BIT_MCD];
        cmp_en_d  = SFR_REQ_IN.wdata[BIT_CMP];
        usb_en_d  = SFR_REQ_IN.wdata[BIT_USB];
        sw_req_d  = SFR_REQ_IN.wdata[BIT_SW];
      end
    end
    // Detector, comparator and bus drop out after a reset for firmware to select again; power-on reselects the monitor
    if (state_q == ST_RELEASE) begin
      mcd_en_d = 1'b0;
      cmp_en_d = 1'b0;
      usb_en_d = 1'b0;
      if (cause_q.por) begin
        mon_sel_d = 1'b1;
      end
    end
  end

  // Monitor enable comes up on only at power-on and survives other resets
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      mon_en_q  <= 1'b1;
      mon_sel_q <= 1'b1;
      mcd_en_q  <= 1'b0;
      cmp_en_q  <= 1'b0;
      usb_en_q  <= 1'b0;
      sw_req_q  <= 1'b0;
    end else begin
      mon_en_q  <= mon_en_d;
      mon_sel_q <= mon_sel_d;
      mcd_en_q  <= mcd_en_d;
      cmp_en_q  <= cmp_en_d;
      usb_en_q  <= usb_en_d;
      sw_req_q  <= sw_req_d;
    end
  end

  // ****************************************
  // Lost clock detector and bus supply edge
  // ****************************************
  // Any change of the watched clock level retriggers the one-shot
  always_comb begin
    clk_lvl_d = SYSCLK_LEVEL_IN;
    vbus_d    = VBUS_IN;
    mcd_cnt_d = mcd_cnt_q;
    if (!running || !mcd_en_q || (SYSCLK_LEVEL_IN != clk_lvl_q)) begin
      mcd_cnt_d = '0;
    end else if (mcd_cnt_q < to16(MCD_COUNT)) begin
      mcd_cnt_d = mcd_cnt_q + 16'h0001;
    end
  end

  // Registers detector state
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      clk_lvl_q <= 1'b0;
      vbus_q    <= 1'b0;
      mcd_cnt_q <= '0;
    end else begin
      clk_lvl_q <= clk_lvl_d;
      vbus_q    <= vbus_d;
      mcd_cnt_q <= mcd_cnt_d;
    end
  end

  // ****************************************
  // Watchdog
  // ****************************************
  assign wdt_tick = (div_q == 4'(WDT_DIVIDE - 1));

  // Tick divider, watchdog count, service and disable
  always_comb begin
    div_d    = wdt_tick ? 4'h0 : div_q + 4'h1;
    wdt_en_d = wdt_en_q;
    wdt_d    = wdt_q;
    if (!running) begin
      wdt_en_d = 1'b1;
      wdt_d    = '0;
      div_d    = 4'h0;
    end else if (WDT_DISABLE_IN) begin
      wdt_en_d = 1'b0;
      wdt_d    = '0;
    end else if (WDT_SERVICE_IN) begin
      wdt_d = '0;
    end else if (wdt_en_q && wdt_tick && (wdt_q < to16(WDT_TICKS))) begin
      wdt_d = wdt_q + 16'h0001;
    end
  end

  // Registers the watchdog
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      div_q    <= 4'h0;
      wdt_en_q <= 1'b1;
      wdt_q    <= '0;
    end else begin
      div_q    <= div_d;
      wdt_en_q <= wdt_en_d;
      wdt_q    <= wdt_d;
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  // Read data registered one cycle after the read strobe
  always_comb begin
    rdata_d = 8'h00;
    if (SFR_REQ_IN.rd) begin
      case (SFR_REQ_IN.addr)
        ADDR_MON_CTRL:  rdata_d = {mon_en_q, SUPPLY_OK_IN, MON_UNUSED};
        ADDR_RST_CAUSE: rdata_d = flags_q;
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  // Registers read data
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign SFR_RDATA_OUT  = rdata_q;
  assign SYS_RST_N_OUT  = running;
  assign MON_ENABLE_OUT = mon_en_q;
  assign RST_PIN_OUT    = 1'b0;
  // Only a power-on or monitor reset pulls the pin; all others leave it
  assign RST_PIN_OE_OUT = state_q[1] && cause_q.por;

endmodule : reset_source_controller

`default_nettype wire

// File: verilog/reset_cause_pkg.sv
// Constants, field layouts and carrier types for the reset source controller.
// Assumes one 125 MHz clock and an 8-bit special register bus.
package reset_cause_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] ADDR_MON_CTRL  = 8'hff;  // supply_monitor_control
  localparam logic [7:0] ADDR_RST_CAUSE = 8'hef;  // reset_cause_register

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MON_EN_BIT   = 7;  // monitor_enable_bit
  localparam int MON_STAT_BIT = 6;  // supply_level_status
  localparam int BIT_PIN      = 0;  // pin_reset_flag
  localparam int BIT_POR      = 1;  // power_on_flag / monitor select
  localparam int BIT_MCD      = 2;  // lost_clock_flag / detector enable
  localparam int BIT_WDT      = 3;  // watchdog_reset_flag
  localparam int BIT_SW       = 4;  // soft_reset_flag / force
  localparam int BIT_CMP      = 5;  // comparator_reset_enable_flag
  localparam int BIT_FLASH    = 6;  // flash_fault_flag
  localparam int BIT_USB      = 7;  // bus_reset_flag / enable

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [7:0] CAUSE_NONE     = 8'h00;  // No cause recorded
  localparam logic [7:0] CAUSE_POR      = 8'h02;  // Power-on cause pattern
  localparam logic [5:0] MON_UNUSED     = 6'h00;  // Unused monitor bits read
  localparam int         CLK_PERIOD_NS  = 8;      // 125 MHz
  localparam int         MCD_TIMEOUT_NS = 100000; // Lost clock time-out
  localparam int         MCD_CYCLES     = MCD_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int         WDT_DIVIDE     = 12;     // Watchdog tick divider
  localparam int         HOLD_CYCLES    = 16;     // Least reset length
  localparam int         WDT_LIMIT      = 256;    // Watchdog ticks to expiry

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic       wr;     // Write strobe, one cycle
    logic       rd;     // Read strobe, one cycle
    logic [7:0] addr;   // Register address
    logic [7:0] wdata;  // Write data
  } sfr_req_t;

  typedef struct packed {
    logic usb;
    logic flash;
    logic cmp;
    logic sw;
    logic wdt;
    logic lost_clock_detector;
    logic por;
    logic pin;
  } cause_t;

  // One-hot sequencer states
  typedef enum logic [2:0] {
    ST_RUN     = 3'b001,
    ST_HOLD    = 3'b010,
    ST_RELEASE = 3'b100
  } seq_state_t;

endpackage : reset_cause_pkg

// File: test/reset_source_monitor.sv
// Checker for the reset source controller, watching only its top-level ports.
// Assumes one clock domain; it is attached by the bind at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module reset_source_monitor
  import reset_cause_pkg::*;
#(
  parameter int MCD_COUNT  = 20,  // Lost clock time-out in cycles
  parameter int WDT_TICKS  = 4,   // Watchdog expiry in ticks
  parameter int HOLD_COUNT = 2    // Least hold in reset
) (
  // Clock and power-on reset
  input wire logic       CLOCK_IN,
  input wire logic       NRST_IN,
  // Watched ports
  input wire sfr_req_t   SFR_REQ_IN,
  input wire logic [7:0] SFR_RDATA_OUT,
  input wire logic       RST_PIN_IN,
  input wire logic       RST_PIN_OE_OUT,
  input wire logic       SUPPLY_OK_IN,
  input wire logic       FLASH_ERR_IN,
  input wire logic       SYS_RST_N_OUT,
  input wire logic       MON_ENABLE_OUT
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic [7:0] low_cnt_q;  // Cycles spent in reset, saturating
  logic [7:0] low_cnt_d;
  logic       mon_rd;     // Monitor register read this cycle
  logic       mon_wr;     // Monitor register write accepted this cycle
  assign mon_rd = SFR_REQ_IN.rd && SFR_REQ_IN.addr == ADDR_MON_CTRL;
  assign mon_wr = SYS_RST_N_OUT && SFR_REQ_IN.wr && SFR_REQ_IN.addr == ADDR_MON_CTRL;
  // Next count; saturates so a long hold cannot wrap into a short one
  always_comb begin
    low_cnt_d = SYS_RST_N_OUT ? 8'h00 : (low_cnt_q == 8'hff ? low_cnt_q : low_cnt_q + 8'h01);
  end
  // Count register
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) low_cnt_q <= 8'h00;
    else low_cnt_q <= low_cnt_d;
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!NRST_IN);
  a_pin_only_reset:
    assert property (RST_PIN_OE_OUT |-> !SYS_RST_N_OUT) else $error("Reset pin driven outside reset");
  a_soft_force:
    assert property (SYS_RST_N_OUT && SFR_REQ_IN.wr && SFR_REQ_IN.addr == ADDR_RST_CAUSE
      && SFR_REQ_IN.wdata[BIT_SW] |-> ##[2:3] !SYS_RST_N_OUT) else $error("Soft reset not entered");
  a_unused_zero:
    assert property (mon_rd |=> SFR_RDATA_OUT[5:0] == MON_UNUSED) else $error("Unused bits not zero");
  a_status_live:
    assert property (mon_rd |=> SFR_RDATA_OUT[MON_STAT_BIT] == $past(SUPPLY_OK_IN)) else $error("Status bit wrong");
  a_enable_read:
    assert property (mon_rd |=> SFR_RDATA_OUT[MON_EN_BIT] == $past(MON_ENABLE_OUT)) else $error("Enable bit wrong");
  a_enable_write:
    assert property (mon_wr |=> MON_ENABLE_OUT == $past(SFR_REQ_IN.wdata[MON_EN_BIT])) else $error("Enable not written");
  a_enable_kept:
    assert property (!mon_wr |=> $stable(MON_ENABLE_OUT)) else $error("Monitor enable changed by itself");
  a_pin_reset:
    assert property (SYS_RST_N_OUT && !RST_PIN_IN |-> ##[1:3] !SYS_RST_N_OUT) else $error("Pin reset missed");
  a_flash_reset:
    assert property (SYS_RST_N_OUT && FLASH_ERR_IN |-> ##[1:3] !SYS_RST_N_OUT) else $error("Flash reset missed");
  a_hold_length:
    assert property ($rose(SYS_RST_N_OUT) |-> low_cnt_q >= HOLD_COUNT + 1) else $error("Reset held too short");
endmodule : reset_source_monitor
bind reset_source_controller reset_source_monitor #(
  .MCD_COUNT(MCD_COUNT), .WDT_TICKS(WDT_TICKS), .HOLD_COUNT(HOLD_COUNT)
) reset_source_monitor_i (
  .CLOCK_IN(CLOCK_IN), .NRST_IN(NRST_IN), .SFR_REQ_IN(SFR_REQ_IN), .SFR_RDATA_OUT(SFR_RDATA_OUT),
  .RST_PIN_IN(RST_PIN_IN), .RST_PIN_OE_OUT(RST_PIN_OE_OUT), .SUPPLY_OK_IN(SUPPLY_OK_IN),
  .FLASH_ERR_IN(FLASH_ERR_IN), .SYS_RST_N_OUT(SYS_RST_N_OUT), .MON_ENABLE_OUT(MON_ENABLE_OUT)
);
`default_nettype wire

// File: test/reset_pin_partner.sv
// External reset circuitry: the open-drain reset pin with its pull-up.
// Assumes the device drives only low, and only while its enable is high.
`timescale 1ns/100ps
`default_nettype none
module reset_pin_partner (
  // Outside push-button or supervisor
  input  wire logic ext_low_in,
  // Device side of the pin
  input  wire logic dev_data_in,
  input  wire logic dev_oe_in,
  // Resolved pin level
  output logic      pin_out
);
  // Pull-up wins unless someone sinks the line
  assign pin_out = !(ext_low_in || (dev_oe_in && !dev_data_in));
endmodule : reset_pin_partner
`default_nettype wire

// File: test/reset_source_controller_bench.sv
// Self-checking bench for the reset source controller.
// Assumes the checker is bound in and the pin partner resolves the reset pin.
`timescale 1ns/100ps
`default_nettype none
module reset_source_controller_bench;
  import reset_cause_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  typedef struct packed {
    logic [7:0] sel;  // Source select written first
    logic [2:0] act;  // Stimulus that provokes the reset
    logic [7:0] exp;  // Cause flags expected afterwards
  } row_t;
  logic       clk, nrst, pin_low, sclk, clk_run, cmp, svc, ferr, fwr, vbus, supply;
  logic       usb_on, usb_rst, wdis;  // Bus controller on, bus reset signalling, watchdog stop
  sfr_req_t   req;       // Register bus request
  logic [7:0] rdata, got;
  logic       pin, pin_dat, oe, sys_n, mon_en;
  int         mismatches, n_compared;
  row_t       rows [8] = '{
    '{8'h10, 3'h0, 8'h10}, '{8'h00, 3'h1, 8'h01}, '{8'h20, 3'h2, 8'h20}, '{8'h00, 3'h3, 8'h40},
    '{8'h80, 3'h4, 8'h80}, '{8'h04, 3'h5, 8'h04}, '{8'h00, 3'h6, 8'h08}, '{8'h02, 3'h7, 8'h02}};
  // ****************************************
  // Design and partner
  // ****************************************
  reset_source_controller #(.MCD_COUNT(20), .WDT_TICKS(4), .HOLD_COUNT(2)) reset_source_controller_i (
    .CLOCK_IN(clk), .NRST_IN(nrst), .SFR_REQ_IN(req), .SFR_RDATA_OUT(rdata), .RST_PIN_IN(pin),
    .RST_PIN_OUT(pin_dat), .RST_PIN_OE_OUT(oe), .SUPPLY_OK_IN(supply), .SYSCLK_LEVEL_IN(sclk),
    .CMP_OUT_IN(cmp), .WDT_SERVICE_IN(svc), .WDT_DISABLE_IN(wdis), .FLASH_ERR_IN(ferr),
    .FLASH_WRITE_IN(fwr), .USB_ENABLED_IN(usb_on), .USB_BUS_RESET_IN(usb_rst), .VBUS_IN(vbus),
    .SYS_RST_N_OUT(sys_n), .MON_ENABLE_OUT(mon_en));
  reset_pin_partner reset_pin_partner_i (.ext_low_in(pin_low), .dev_data_in(pin_dat), .dev_oe_in(oe), .pin_out(pin));
  // ****************************************
  // Clock, watched clock and tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Watched clock toggles every cycle unless a stall is wanted
  always @(posedge clk) begin
    #1;
    if (clk_run) sclk = ~sclk;
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  // An idle edge follows each strobe, so back-to-back calls never re-raise it in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1; req.addr = a; req.wdata = d;
    tick();
    req.wr = 1'b0;
    tick();
  endtask : wr
  // Read data is registered, so it stands in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req.rd = 1'b1; req.addr = a;
    tick();
    req.rd = 1'b0;
    d = rdata;
    tick();
  endtask : rd
  // Bounded wait for the system reset to reach a level
  task automatic wait_rst(input logic lvl);
    for (int k = 0; k < 300 && sys_n !== lvl; k++) tick();
    if (sys_n !== lvl) begin
      check("system reset", {7'h00, lvl}, {7'h00, sys_n});
      end_of_test();
    end
  endtask : wait_rst
  task automatic act(input logic [2:0] a, input logic on);
    case (a)
      3'h1: pin_low = on;
      3'h2: cmp = !on;
      3'h3: ferr = on;
      3'h4: if (on) vbus = !vbus;
      3'h5: clk_run = !on;
      3'h6: svc = !on;
      3'h7: supply = !on;
      default: ;
    endcase
  endtask : act
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {nrst, pin_low, sclk, ferr, fwr, vbus, usb_on, usb_rst, wdis} = '0;
    {clk_run, cmp, svc, supply} = '1;
    req = '0;
    mismatches = 0;
    n_compared = 0;
    repeat (4) tick();
    nrst = 1'b1;
    wait_rst(1'b1);
    // Each row provokes one cause; settled sources are selected only after enabling
    foreach (rows[i]) begin
      if (rows[i].sel != 8'h00) wr(ADDR_RST_CAUSE, rows[i].sel);
      act(rows[i].act, 1'b1);
      wait_rst(1'b0);
      check("pin drive", {7'h00, rows[i].exp == CAUSE_POR}, {7'h00, oe});
      act(rows[i].act, 1'b0);
      wait_rst(1'b1);
      rd(ADDR_RST_CAUSE, got);
      check("cause flags", rows[i].exp, got);
    end
    // Second power-on reset in mid-run
    nrst = 1'b0;
    repeat (2) tick();
    nrst = 1'b1;
    wait_rst(1'b1);
    rd(ADDR_RST_CAUSE, got);
    check("power-on flags", CAUSE_POR, got);
    rd(ADDR_MON_CTRL, got);
    check("monitor control", 8'hc0, got);
    // Deselected monitor and disabled detector must not reset
    wr(ADDR_RST_CAUSE, 8'h04);
    wr(ADDR_RST_CAUSE, 8'h00);
    supply = 1'b0;
    clk_run = 1'b0;
    repeat (40) tick();
    check("no reset", 8'h01, {7'h00, sys_n});
    // Status is read while the supply is still low
    rd(ADDR_MON_CTRL, got);
    check("status low", 8'h80, got);
    supply = 1'b1;
    clk_run = 1'b1;
    // A stopped watchdog must not expire even when left unserviced
    wdis = 1'b1;
    tick();
    wdis = 1'b0;
    svc = 1'b0;
    repeat (80) tick();
    check("watchdog stopped", 8'h01, {7'h00, sys_n});
    svc = 1'b1;
    wr(ADDR_MON_CTRL, 8'h3f);
    rd(ADDR_MON_CTRL, got);
    check("monitor off", 8'h40, got);
    // Flash write with the monitor off is an illegal access
    fwr = 1'b1;
    wait_rst(1'b0);
    fwr = 1'b0;
    wait_rst(1'b1);
    rd(ADDR_RST_CAUSE, got);
    check("flash flags", 8'h40, got);
    check("monitor kept", 8'h00, {7'h00, mon_en});
    // Bus reset signalling counts only while the bus controller is enabled
    wr(ADDR_RST_CAUSE, 8'h80);
    usb_rst = 1'b1;
    repeat (8) tick();
    check("bus off no reset", 8'h01, {7'h00, sys_n});
    usb_on = 1'b1;
    wait_rst(1'b0);
    {usb_on, usb_rst} = '0;
    wait_rst(1'b1);
    rd(ADDR_RST_CAUSE, got);
    check("bus reset flags", 8'h80, got);
    rd(8'h00, got);
    check("unmapped read", 8'h00, got);
    end_of_test();
  end
endmodule : reset_source_controller_bench
`default_nettype wire
